// >>> src/piwt_backend.sv
// user backend: apb registers, qword buffer, requests to the core
// assumes an apb master on ref_clk; pready is always high
`timescale 1ns/1ps
module piwt_backend (
    input wire logic ref_clk,
    input wire logic sys_rst,
    piwt_if.backend lnk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    piwt_pkg::piwt_back_state_t state;
    logic [31:0] mem_lo [piwt_pkg::BUF_DEPTH];
    logic [31:0] mem_hi [piwt_pkg::BUF_DEPTH];
    logic [31:0] base_addr;
    logic [3:0] len_qw;
    logic [2:0] bidx;
    logic ctl_write;
    logic busy;
    logic fb_seen;
    logic aborted;
    logic narrow;
    logic [4:0] done_dw;
    logic [4:0] fetch_dw;
    logic [4:0] launch_cnt;
    logic [4:0] n_units;

    // apb decode; every access answers in its first access cycle
    wire apb_wr = psel && penable && pwrite;
    wire hit_ctrl = (paddr == piwt_pkg::OFS_CTRL);
    wire hit_addr = (paddr == piwt_pkg::OFS_ADDR);
    wire hit_len = (paddr == piwt_pkg::OFS_LEN);
    wire hit_stat = (paddr == piwt_pkg::OFS_STAT);
    wire hit_bidx = (paddr == piwt_pkg::OFS_BIDX);
    wire hit_blo = (paddr == piwt_pkg::OFS_BLO);
    wire hit_bhi = (paddr == piwt_pkg::OFS_BHI);
    wire mapped = hit_ctrl || hit_addr || hit_len || hit_stat ||
        hit_bidx || hit_blo || hit_bhi;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    wire [31:0] rd_mux = hit_ctrl ? {30'h0000_0000, ctl_write, 1'b0} :
        hit_addr ? base_addr :
        hit_len ? {28'h000_0000, len_qw} :
        hit_stat ? {19'h0_0000, done_dw, 5'h00, aborted, fb_seen, busy} :
        hit_bidx ? {29'h0000_0000, bidx} :
        hit_blo ? mem_lo[bidx] :
        hit_bhi ? mem_hi[bidx] : 32'h0000_0000;

    // read word latched in setup so prdata leaves a flop
    always_ff @(posedge ref_clk) begin
        if (psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    // remaining work and the word offered to the core
    wire go = apb_wr && hit_ctrl && pwdata[0] && !busy;
    wire [4:0] total_dw = {len_qw, 1'b0};
    wire [4:0] left_dw = total_dw - done_dw;
    wire [2:0] fq = fetch_dw[3:1];
    wire [31:0] restart_addr = base_addr + {25'h000_0000, done_dw, 2'b00};
    wire [63:0] wr_word = narrow ?
        {32'h0000_0000, fetch_dw[0] ? mem_hi[fq] : mem_lo[fq]} :
        {mem_hi[fq], mem_lo[fq]};
    wire running = (state == piwt_pkg::PIWT_B_WAIT) ||
        (state == piwt_pkg::PIWT_B_RUN);
    wire dword_mode = narrow || lnk.init_wide_fallback;
    wire [2:0] dq = done_dw[3:1];

    assign lnk.wide_request_pulse = (state == piwt_pkg::PIWT_B_REQ) &&
        !narrow;
    assign lnk.narrow_request_pulse = (state == piwt_pkg::PIWT_B_REQ) &&
        narrow;
    assign lnk.internal_addr_data_bus = !lnk.addr_phase_n ?
        {32'h0000_0000, restart_addr} :
        (lnk.init_data_phase && lnk.init_write_not_read) ?
        wr_word : 64'h0000_0000_0000_0000;
    assign lnk.init_byte_enable_cmd = !lnk.addr_phase_n ?
        {piwt_pkg::CBE_IDLE, ctl_write ? piwt_pkg::CMD_MEM_WRITE :
        piwt_pkg::CMD_MEM_READ_MULT} : 8'h00;
    assign lnk.backend_ready = busy;
    // raised while the phase being launched is the last one
    assign lnk.complete = running &&
        ((launch_cnt + 5'h01) >= n_units);

    // buffer: apb access, read data stored per accepted word
    always_ff @(posedge ref_clk) begin
        if (lnk.init_xfer_accepted && !lnk.init_write_not_read) begin
            if (!dword_mode) begin
                mem_lo[dq] <= lnk.core_read_data[31:0];
                mem_hi[dq] <= lnk.core_read_data[63:32];
            end else if (done_dw[0]) begin
                mem_hi[dq] <= lnk.core_read_data[31:0];
            end else begin
                mem_lo[dq] <= lnk.core_read_data[31:0];
            end
        end else if (apb_wr && hit_blo) begin
            mem_lo[bidx] <= pwdata;
        end else if (apb_wr && hit_bhi) begin
            mem_hi[bidx] <= pwdata;
        end
    end

    // registers and transfer sequencing
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= piwt_pkg::PIWT_B_IDLE;
            base_addr <= piwt_pkg::RST_ADDR;
            len_qw <= piwt_pkg::RST_LEN;
            bidx <= 3'h0;
            ctl_write <= 1'b0;
            busy <= 1'b0;
            fb_seen <= 1'b0;
            aborted <= 1'b0;
            narrow <= 1'b0;
            done_dw <= 5'h00;
            fetch_dw <= 5'h00;
            launch_cnt <= 5'h00;
            n_units <= 5'h00;
        end else begin
            if (apb_wr && hit_ctrl && !busy) begin
                ctl_write <= pwdata[1];
            end
            if (apb_wr && hit_addr && !busy) begin
                base_addr <= {pwdata[31:2], 2'b00};
            end
            if (apb_wr && hit_len && !busy) begin
                len_qw <= pwdata[3:0];
            end
            if (apb_wr && hit_bidx) begin
                bidx <= pwdata[2:0];
            end
            if (lnk.init_wide_fallback && lnk.init_data_phase) begin
                fb_seen <= 1'b1;
            end
            if (lnk.init_master_abort) begin
                aborted <= 1'b1;
            end
            if (lnk.init_source_advance) begin
                launch_cnt <= launch_cnt + 5'h01;
                if (lnk.init_write_not_read) begin
                    fetch_dw <= fetch_dw + (narrow ? 5'h01 : 5'h02);
                end
            end
            if (lnk.init_xfer_accepted) begin
                done_dw <= done_dw + (dword_mode ? 5'h01 : 5'h02);
            end
            case (state)
                piwt_pkg::PIWT_B_IDLE: begin
                    if (go) begin
                        busy <= 1'b1;
                        fb_seen <= 1'b0;
                        aborted <= 1'b0;
                        narrow <= 1'b0;
                        done_dw <= 5'h00;
                        fetch_dw <= 5'h00;
                        state <= piwt_pkg::PIWT_B_REQ;
                    end
                end
                piwt_pkg::PIWT_B_REQ: begin
                    launch_cnt <= 5'h00;
                    n_units <= narrow ? left_dw : {1'b0, left_dw[4:1]};
                    state <= piwt_pkg::PIWT_B_WAIT;
                end
                piwt_pkg::PIWT_B_WAIT: begin
                    if (lnk.init_data_phase) begin
                        state <= piwt_pkg::PIWT_B_RUN;
                    end
                end
                piwt_pkg::PIWT_B_RUN: begin
                    if (!lnk.init_data_phase) begin
                        state <= piwt_pkg::PIWT_B_END;
                    end
                end
                piwt_pkg::PIWT_B_END: begin
                    // drop words fetched but never taken by the target
                    fetch_dw <= done_dw;
                    if (done_dw >= total_dw || aborted) begin
                        busy <= 1'b0;
                        state <= piwt_pkg::PIWT_B_IDLE;
                    end else begin
                        narrow <= narrow || fb_seen || done_dw[0];
                        state <= piwt_pkg::PIWT_B_REQ;
                    end
                end
                default: begin
                    state <= piwt_pkg::PIWT_B_IDLE;
                end
            endcase
        end
    end
endmodule : piwt_backend

// >>> src/piwt_core.sv
// initiator core: runs the bus side of wide and narrow master transfers
// assumes bus pins are synchronous to ref_clk (it is the bus clock) and
// that the pad ring resolves pin levels from the output enables
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
module piwt_core (
    input wire logic ref_clk,
    input wire logic sys_rst,
    piwt_if.core lnk,
    output logic req_n,
    input wire logic gnt_n,
    output logic frame_n_o,
    output logic req64_n_o,
    output logic irdy_n_o,
    output logic ctl_oe,
    output logic [7:0] cbe_n_o,
    input wire logic [63:0] ad_i,
    output logic [63:0] ad_o,
    output logic ad_oe,
    input wire logic devsel_n,
    input wire logic trdy_n,
    input wire logic stop_n,
    input wire logic ack64_n
);
    piwt_pkg::piwt_core_state_t state;
    logic gnt_seen;
    logic wide;
    logic is_write;
    logic fb;
    logic half;
    logic claimed;
    logic acc;
    logic abort;
    logic [3:0] wait_cnt;
    logic [63:0] rdata;

    // bus decode, all combinational on registered state
    wire in_data = (state == piwt_pkg::PIWT_DATA);
    wire xfer = in_data && !irdy_n_o && !trdy_n;
    wire claim32 = wide && !devsel_n && ack64_n;
    wire fb_now = fb || claim32;
    wire split_now = xfer && fb_now && !half;
    wire launch = (state == piwt_pkg::PIWT_ADDR) ||
        (xfer && stop_n && !frame_n_o && !split_now);
    wire no_claim = in_data && devsel_n && !claimed &&
        (wait_cnt == piwt_pkg::DEVSEL_TIMEOUT);
    wire [63:0] next_word = wide ? lnk.internal_addr_data_bus :
        {32'h0000_0000, lnk.internal_addr_data_bus[31:0]};
    wire [7:0] next_be = wide ? lnk.init_byte_enable_cmd :
        {piwt_pkg::CBE_IDLE, lnk.init_byte_enable_cmd[3:0]};

    // backend-facing strobes
    assign lnk.addr_phase_n = (state != piwt_pkg::PIWT_APREP);
    assign lnk.init_data_phase = (state == piwt_pkg::PIWT_ADDR) || in_data;
    assign lnk.init_source_advance = launch;
    assign lnk.init_write_not_read = is_write;
    assign lnk.init_wide_fallback = fb;
    assign lnk.init_xfer_accepted = acc;
    assign lnk.core_read_data = rdata;
    assign lnk.init_master_abort = abort;

    // status flops: accepted pulse, read capture, fallback, devsel watch
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            acc <= 1'b0;
            rdata <= 64'h0000_0000_0000_0000;
            fb <= 1'b0;
            claimed <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            acc <= xfer;
            if (xfer && !is_write) begin
                rdata <= ad_i; // narrow dwords always land on low lanes
            end
            if (state == piwt_pkg::PIWT_APREP) begin
                fb <= 1'b0;
                claimed <= 1'b0;
                wait_cnt <= 4'h0;
            end else if (in_data) begin
                if (claim32) begin
                    fb <= 1'b1;
                end
                if (!devsel_n) begin
                    claimed <= 1'b1;
                end
                if (wait_cnt != piwt_pkg::DEVSEL_TIMEOUT) begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end

    // bus sequencer
    // the pins are launched from flops so the phase timing is exact
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= piwt_pkg::PIWT_IDLE;
            req_n <= 1'b1;
            frame_n_o <= 1'b1;
            req64_n_o <= 1'b1;
            irdy_n_o <= 1'b1;
            ctl_oe <= 1'b0;
            cbe_n_o <= 8'hFF;
            ad_o <= 64'h0000_0000_0000_0000;
            ad_oe <= 1'b0;
            gnt_seen <= 1'b0;
            wide <= 1'b0;
            is_write <= 1'b0;
            half <= 1'b0;
            abort <= 1'b0;
        end else begin
            abort <= 1'b0;
            case (state)
                piwt_pkg::PIWT_IDLE: begin
                    gnt_seen <= 1'b0;
                    half <= 1'b0;
                    if (lnk.wide_request_pulse || lnk.narrow_request_pulse) begin
                        wide <= lnk.wide_request_pulse;
                        req_n <= 1'b0;
                        state <= piwt_pkg::PIWT_REQ;
                    end
                end
                piwt_pkg::PIWT_REQ: begin
                    // a single-clock grant glitch must not start a frame
                    gnt_seen <= !gnt_n;
                    if (!gnt_n && gnt_seen) begin
                        state <= piwt_pkg::PIWT_APREP;
                    end
                end
                piwt_pkg::PIWT_APREP: begin
                    req_n <= 1'b1;
                    ad_o <= {32'h0000_0000,
                        lnk.internal_addr_data_bus[31:0]};
                    cbe_n_o <= {piwt_pkg::CBE_IDLE,
                        lnk.init_byte_enable_cmd[3:0]};
                    is_write <= (lnk.init_byte_enable_cmd[3:0] ==
                        piwt_pkg::CMD_MEM_WRITE);
                    frame_n_o <= 1'b0;
                    req64_n_o <= !wide;
                    ctl_oe <= 1'b1;
                    ad_oe <= 1'b1;
                    state <= piwt_pkg::PIWT_ADDR;
                end
                piwt_pkg::PIWT_ADDR: begin
                    cbe_n_o <= next_be;
                    if (is_write) begin
                        ad_o <= next_word;
                    end
                    ad_oe <= is_write; // read turnaround releases ad
                    irdy_n_o <= !lnk.backend_ready;
                    if (lnk.complete) begin
                        frame_n_o <= 1'b1;
                        req64_n_o <= 1'b1;
                    end
                    state <= piwt_pkg::PIWT_DATA;
                end
                piwt_pkg::PIWT_DATA: begin
                    if (no_claim || (!stop_n && frame_n_o) ||
                        (xfer && frame_n_o)) begin
                        // last phase done, disconnected, or nobody claimed
                        abort <= no_claim;
                        irdy_n_o <= 1'b1;
                        frame_n_o <= 1'b1;
                        req64_n_o <= 1'b1;
                        ad_oe <= 1'b0;
                        state <= piwt_pkg::PIWT_TURN;
                    end else if (!stop_n) begin
                        frame_n_o <= 1'b1;
                        req64_n_o <= 1'b1;
                    end else if (split_now) begin
                        // second dword is the last one this frame will offer
                        half <= 1'b1;
                        irdy_n_o <= 1'b1;
                        frame_n_o <= 1'b1;
                        req64_n_o <= 1'b1;
                        ad_o[31:0] <= ad_o[63:32];
                        cbe_n_o[3:0] <= cbe_n_o[7:4];
                    end else if (xfer) begin
                        if (is_write) begin
                            ad_o <= next_word;
                        end
                        cbe_n_o <= next_be;
                        frame_n_o <= lnk.complete;
                        req64_n_o <= lnk.complete || !wide;
                        irdy_n_o <= !lnk.backend_ready;
                    end else begin
                        irdy_n_o <= !lnk.backend_ready;
                    end
                end
                piwt_pkg::PIWT_TURN: begin
                    ctl_oe <= 1'b0;
                    cbe_n_o <= 8'hFF;
                    state <= piwt_pkg::PIWT_IDLE;
                end
                default: begin
                    state <= piwt_pkg::PIWT_IDLE;
                end
            endcase
        end
    end
endmodule : piwt_core

// >>> src/piwt_if.sv
// link between the bus-side initiator core and the user backend
// assumes both ends run on the same ref_clk; no clocking block
`timescale 1ns/1ps
interface piwt_if;
    logic wide_request_pulse;
    logic narrow_request_pulse;
    logic addr_phase_n;
    logic init_data_phase;
    logic [63:0] internal_addr_data_bus;
    logic [63:0] core_read_data;
    logic [7:0] init_byte_enable_cmd;
    logic backend_ready;
    logic complete;
    logic init_xfer_accepted;
    logic init_source_advance;
    logic init_write_not_read;
    logic init_wide_fallback;
    logic init_master_abort;
    modport core (
        input wide_request_pulse, narrow_request_pulse,
        input internal_addr_data_bus, init_byte_enable_cmd,
        input backend_ready, complete,
        output addr_phase_n, init_data_phase, core_read_data,
        output init_xfer_accepted, init_source_advance,
        output init_write_not_read, init_wide_fallback, init_master_abort
    );
    modport backend (
        output wide_request_pulse, narrow_request_pulse,
        output internal_addr_data_bus, init_byte_enable_cmd,
        output backend_ready, complete,
        input addr_phase_n, init_data_phase, core_read_data,
        input init_xfer_accepted, init_source_advance,
        input init_write_not_read, init_wide_fallback, init_master_abort
    );
endinterface : piwt_if

// >>> src/piwt_pkg.sv
// shared constants and types for the wide-transfer initiator and its backend
// assumes one 25 MHz clock (ref_clk) and a synchronous active-high reset
//
// Contract
// - backend pulses wide request exactly one clock
// - frame and req64 only after grant two clocks
// - address-phase strobe one clock before frame
// - frame cycle drives latched address and command
// - data state follows address strobe; backend byte enables
// - backend drives write data during write data state
// - irdy asserted one clock after frame
// - backend holds ready; complete on next-to-last phase
// - frame and req64 drop at final phase
// - accepted pulse per word; advance pulse fetches next
// - no own wait states while both ready
// - write indication high through write transaction
// - target disconnect: stop low, trdy high
// - backend rolls back over-fetched words
// - narrow claim: irdy drops after first dword
// - core moves upper lanes onto lower lanes
// - only wait state is the narrow-claim one
// - fallback flag on narrow claim of wide request
// - backend counts dwords from accepted and fallback
// - at most two dwords after narrow claim
// - backend restarts remainder as narrow transaction
// - backend counts dwords actually transferred
// - write indication low through read transaction
package piwt_pkg;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
    localparam logic [3:0] CBE_IDLE = 4'hF;
    localparam logic [3:0] DEVSEL_TIMEOUT = 4'h5;
    localparam int BUF_DEPTH = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_LEN = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_BIDX = 8'h10;
    localparam logic [7:0] OFS_BLO = 8'h14;
    localparam logic [7:0] OFS_BHI = 8'h18;
    localparam logic [31:0] RST_ADDR = 32'h0000_0000;
    localparam logic [3:0] RST_LEN = 4'h1;
    typedef enum logic [2:0] {
        PIWT_IDLE, PIWT_REQ, PIWT_APREP, PIWT_ADDR, PIWT_DATA, PIWT_TURN
    } piwt_core_state_t;
    typedef enum logic [2:0] {
        PIWT_B_IDLE, PIWT_B_REQ, PIWT_B_WAIT, PIWT_B_RUN, PIWT_B_END
    } piwt_back_state_t;
endpackage : piwt_pkg

// >>> tb/piwt_assertions.sv
// concurrent checks on the core side of the link and on its bus pins
// assumes it sits beside piwt_if in the bench, everything on ref_clk
`timescale 1ns/1ps
module piwt_assertions (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic addr_phase_n,
    input wire logic init_data_phase,
    input wire logic [7:0] init_byte_enable_cmd,
    input wire logic init_xfer_accepted,
    input wire logic init_write_not_read,
    input wire logic init_wide_fallback,
    input wire logic frame_n_o,
    input wire logic req64_n_o,
    input wire logic irdy_n_o,
    input wire logic [7:0] cbe_n_o,
    input wire logic gnt_n,
    input wire logic devsel_n,
    input wire logic trdy_n,
    input wire logic stop_n,
    input wire logic ack64_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // a word changes hands on this edge
    wire xfer = !irdy_n_o && !trdy_n && !devsel_n;
    // first dword of a wide request taken narrow; stop excluded on purpose
    wire narrow_hit = xfer && ack64_n && !req64_n_o && !frame_n_o && stop_n;
    a_grant_held: assert property ($fell(frame_n_o) |->
        !$past(gnt_n) && !$past(gnt_n, 2)) else $error("frame without grant");
    a_strobe_frame: assert property (!addr_phase_n |=>
        !frame_n_o && init_data_phase) else $error("strobe not before frame");
    a_cmd_passed: assert property ($fell(frame_n_o) |->
        cbe_n_o[3:0] == $past(init_byte_enable_cmd[3:0]))
        else $error("command not passed");
    a_dir_matches: assert property ($fell(frame_n_o) |->
        init_write_not_read == (cbe_n_o[3:0] == piwt_pkg::CMD_MEM_WRITE))
        else $error("direction wrong");
    a_dir_stable: assert property (init_data_phase &&
        $past(init_data_phase) |-> $stable(init_write_not_read))
        else $error("direction moved");
    a_irdy_follows: assert property ($fell(frame_n_o) |=> !irdy_n_o)
        else $error("irdy late");
    a_req64_drop: assert property ($rose(frame_n_o) &&
        !$past(req64_n_o) |-> req64_n_o) else $error("req64 held");
    a_accept_pulse: assert property (xfer |=> init_xfer_accepted)
        else $error("accept missing");
    a_no_wait: assert property (xfer && !frame_n_o && stop_n &&
        (!ack64_n || req64_n_o) |=> !irdy_n_o) else $error("own wait");
    a_narrow_wait: assert property (narrow_hit |=>
        irdy_n_o && frame_n_o ##1 !irdy_n_o) else $error("narrow wait wrong");
    a_fallback_flag: assert property (narrow_hit |->
        ##[0:2] init_wide_fallback) else $error("fallback missing");
    c_narrow: cover property (narrow_hit);
    c_disconnect: cover property ($rose(frame_n_o) && !stop_n);
    c_read: cover property ($fell(frame_n_o) && !init_write_not_read);
endmodule : piwt_assertions

// >>> tb/testbench.sv
// self-checking bench: apb software, arbiter and target on the bus pins
// assumes piwt_core and piwt_backend joined by piwt_if, one 25 MHz clock
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic gnt_n = 1'b1;
    logic [3:0] tgt = 4'hF;
    logic act = 1'b0;
    logic wr = 1'b0;
    logic wide = 1'b0;
    logic [7:0] cur = 8'h00;
    logic [1:0] mode = 2'h0;
    logic [31:0] seed = 32'h4848AE37;
    logic [31:0] arb = 32'h4848AE37;
    logic [31:0] mem [256];
    logic [63:0] bufq [8];
    int ntr = 0;
    int n_fail = 0;
    int tests_run = 0;
    wire [31:0] prdata;
    wire pready, pslverr, req_n, frame_n_o, req64_n_o, irdy_n_o, ctl_oe, ad_oe;
    wire devsel_n, trdy_n, stop_n, ack64_n;
    wire [7:0] cbe_n_o;
    wire [63:0] ad_o, ad_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] pat(input logic [7:0] d);
        return {~d, d, 8'hA5, d};
    endfunction : pat
    piwt_if lnk();
    piwt_core i_piwt_core (.ref_clk, .sys_rst, .lnk(lnk), .req_n, .gnt_n,
        .frame_n_o, .req64_n_o, .irdy_n_o, .ctl_oe, .cbe_n_o, .ad_i, .ad_o,
        .ad_oe, .devsel_n, .trdy_n, .stop_n, .ack64_n);
    piwt_backend i_piwt_backend (.ref_clk, .sys_rst, .lnk(lnk), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    piwt_assertions u_chk (.ref_clk, .sys_rst, .frame_n_o, .req64_n_o,
        .irdy_n_o, .cbe_n_o, .gnt_n, .devsel_n, .trdy_n, .stop_n, .ack64_n,
        .addr_phase_n(lnk.addr_phase_n), .init_data_phase(lnk.init_data_phase),
        .init_byte_enable_cmd(lnk.init_byte_enable_cmd),
        .init_xfer_accepted(lnk.init_xfer_accepted),
        .init_write_not_read(lnk.init_write_not_read),
        .init_wide_fallback(lnk.init_wide_fallback));
    assign {devsel_n, trdy_n, stop_n, ack64_n} = tgt;
    // released bus shows the inverse, so stale data never looks right
    assign ad_i = (act && !wr) ? {pat(cur + 8'h01), pat(cur)} : ~ad_o;
    initial forever #20 ref_clk = ~ref_clk;
    // arbiter: grant after a random delay, then held while requested
    always @(posedge ref_clk) begin
        arb <= lfsr(arb);
        gnt_n <= req_n | (gnt_n & arb[3]);
    end
    // target: mode 0 wide, 1 narrow claim, 2 disconnect after two words
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            act <= 1'b0;
            tgt <= 4'hF;
        end else if (!act && !frame_n_o) begin
            act <= 1'b1;
            cur <= ad_o[9:2];
            wr <= cbe_n_o[3:0] === piwt_pkg::CMD_MEM_WRITE;
            wide <= !req64_n_o && mode != 2'h1;
            ntr <= 0;
            tgt <= {2'b0, 1'b1, req64_n_o || mode == 2'h1};
            if (cbe_n_o[3:0] !== piwt_pkg::CMD_MEM_WRITE) tgt[2] <= 1'b1;
        end else if (act) begin
            if (!irdy_n_o && !trdy_n) begin
                chk({62'h0, ctl_oe, ad_oe}, {62'h0, 1'b1, wr});
                if (wr) mem[cur] <= ad_o[31:0];
                if (wr && wide) mem[cur + 8'h01] <= ad_o[63:32];
                cur <= cur + (wide ? 8'h02 : 8'h01);
                ntr <= ntr + 1;
                if (mode == 2'h2 && ntr == 1) tgt[2:1] <= 2'b10;
            end else if (stop_n) tgt[2] <= 1'b0;
            if (frame_n_o && (!stop_n || (!irdy_n_o && !trdy_n))) begin
                act <= 1'b0;
                tgt <= 4'hF;
            end
        end
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        if (pready !== 1'b1) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (k >= 20) conclude();
    endtask : apb
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        conclude();
    end
    initial begin
        logic [31:0] r, hi;
        logic e;
        logic [7:0] a, d;
        int len, k;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, 8'hFC, 32'h0, r, e);
        chk({e, r}, 64'h1_0000_0000);
        for (int t = 0; t < 6; t++) begin
            seed = lfsr(seed);
            mode = 2'(t % 3);
            len = (t == 0 || t == 4) ? 8 : (t == 3) ? 1 : int'(seed[2:0]) + 1;
            a = {seed[9:5], 3'h0};
            for (int i = 0; i < len; i++) begin
                seed = lfsr(seed);
                bufq[i] = {~seed, seed};
                apb(1'b1, piwt_pkg::OFS_BIDX, 32'(i), r, e);
                apb(1'b1, piwt_pkg::OFS_BLO, seed, r, e);
                apb(1'b1, piwt_pkg::OFS_BHI, ~seed, r, e);
            end
            apb(1'b1, piwt_pkg::OFS_ADDR, {24'h0, a}, r, e);
            apb(1'b1, piwt_pkg::OFS_LEN, 32'(len), r, e);
            apb(1'b1, piwt_pkg::OFS_CTRL, {30'h0, t < 3, 1'b1}, r, e);
            k = 0;
            do begin
                apb(1'b0, piwt_pkg::OFS_STAT, 32'h0, r, e);
                k++;
            end while (r[0] !== 1'b0 && k < 300);
            if (r[0] !== 1'b0) n_fail++;
            if (r[0] !== 1'b0) conclude();
            chk({59'h0, r[12:8]}, 64'(2 * len));
            chk({62'h0, r[2:1]}, {63'h0, mode == 2'h1});
            for (int i = 0; i < len; i++) begin
                d = 8'(a >> 2) + 8'(2 * i);
                if (t < 3) begin
                    chk({mem[d + 8'h01], mem[d]}, bufq[i]);
                end else begin
                    apb(1'b1, piwt_pkg::OFS_BIDX, 32'(i), r, e);
                    apb(1'b0, piwt_pkg::OFS_BLO, 32'h0, r, e);
                    apb(1'b0, piwt_pkg::OFS_BHI, 32'h0, hi, e);
                    chk({hi, r}, {pat(d + 8'h01), pat(d)});
                end
            end
            $display("test %0d mode %0d len %0d done", t, mode, len);
        end
        conclude();
    end
endmodule : testbench
